// file: logic/att_thermal_throttle.sv
`timescale 1ns/10ps
`include "att_params.svh"
// Contract
// - Monitor activates when any sensor reading is at or past max temp minus offset.
// - While active and hot, keep stepping core and graphics operating point down; code has no graphics point and steps the core ratio only.
// - Max junction temp is read-only in target register bits 23:16, offset-independent.
// - Writable offset in bits 29:24 lowers activation point; default zero.
// - Protection is always on; nothing can disable it.
// - After cooling, operating point returns to the normal requested point.
// - Raise voltage before frequency; lower frequency before voltage.
// - Execution continues but stalls during each frequency transition.
// - Requests above thermal target while active are deferred until event ends.
// - Requests below thermal target while active are followed at once.
// - At minimum operating point and still hot, clock modulation engages.
// - Modulation gates core clocks 25 percent on, 75 percent off, fixed.
// - Modulation period is 32 us, counted on the fixed core clock.
// - Deactivate and stop modulation only when cool and hysteresis timer expired.
// - Snoops and interrupts keep working while the monitor is active.
// - One sensor per core; register read returns that core's instantaneous reading.
// - Sideband read returns 256 ms average of the hottest package sensor.
// - Readings are offsets below max temp, saturating at zero, offset-independent.
// - A reading of zero with zero offset activates and logs an event.
// - Rapid temperature rise sets out-of-spec bits in package and core status.
// - Two programmable thresholds per core, each able to raise an interrupt.
// - Sideband temperature stays readable while cores are idle.
// - Single package overheat output asserts when any core reaches activation.
module att_thermal_throttle #(
  parameter int         NCORES      = 2,
  parameter logic [5:0] RATIO_MAX   = 6'h20,
  parameter logic [5:0] RATIO_MIN   = 6'h04,
  parameter logic [7:0] TJMAX       = `ATT_TJMAX_RST,
  parameter int         STEP_CYC    = `ATT_STEP_CYC,
  parameter int         HYST_CYC    = `ATT_HYST_CYC,
  parameter int         SAMPLE_CYC  = `ATT_SAMPLE_CYC,
  parameter int         AVG_CYC     = `ATT_AVG_SAMPLE_CYC,
  parameter int         TRANS_CYC   = `ATT_TRANS_CYC
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      resetn_i,
  input  wire logic [NCORES-1:0][7:0]    sensor_i,
  input  wire logic                      pstate_vld_i,
  input  wire logic [5:0]                pstate_ratio_i,
  input  wire att_pkg::att_msr_req_t     msr_req_i,
  output logic                           msr_ack_o,
  output logic [63:0]                    msr_rdata_o,
  input  wire logic                      sb_temp_req_i,
  output logic                           sb_temp_vld_o,
  output logic [6:0]                     sb_temp_o,
  output logic [5:0]                     freq_ratio_o,
  output logic [5:0]                     volt_level_o,
  output logic                           core_clk_en_o,
  output logic                           exec_stall_o,
  output logic                           overheat_flag_pin_o,
  output logic                           atm_active_o,
  output logic [NCORES-1:0]              thr_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Common strobes
  logic [31:0] smp_cnt;
  logic        smp_tick;
  logic [5:0]  tgt_offset;
  wire  [NCORES-1:0]       hot_w;
  wire  [NCORES-1:0]       oos_w;
  wire  [NCORES-1:0][6:0]  smp_w;
  wire  [NCORES-1:0][63:0] cstat_w;
  wire  [NCORES-1:0][63:0] thr_w;
  logic        msr_wr;

  assign msr_wr = msr_req_i.vld & msr_req_i.wr;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      smp_cnt  <= 32'h0;
      smp_tick <= 1'b0;
    end else if (smp_cnt == 32'(SAMPLE_CYC - 1)) begin
      smp_cnt  <= 32'h0;
      smp_tick <= 1'b1;
    end else begin
      smp_cnt  <= smp_cnt + 32'h1;
      smp_tick <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      tgt_offset <= `ATT_OFFSET_RST;
    end else if (msr_wr && msr_req_i.addr == `ATT_MSR_TARGET) begin
      tgt_offset <= msr_req_i.wdata[`ATT_OFFSET_LSB +: 6];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-core sensor, thresholds and status
  logic act;

  genvar g;
  for (g = 0; g < NCORES; g++) begin : g_core
    logic [6:0] sat;
    logic [6:0] smp;
    logic [6:0] th1;
    logic [6:0] th2;
    logic       en1;
    logic       en2;
    logic       t1;
    logic       t2;
    logic       t1_log;
    logic       t2_log;
    logic       oos_log;
    logic       act_log;
    logic       irq;
    logic       oos_now;
    logic       wsel;
    logic       thsel;

    // Above max temp shows as a negative offset; clamp to zero
    assign sat     = sensor_i[g][7] ? 7'h00 : sensor_i[g][6:0];
    assign oos_now = smp_tick && (smp > sat) && ((smp - sat) >= `ATT_RAPID_DELTA);
    assign wsel    = msr_wr && msr_req_i.addr == `ATT_MSR_CORE_STAT && msr_req_i.core == 4'(g);
    assign thsel   = msr_wr && msr_req_i.addr == `ATT_MSR_THRESH && msr_req_i.core == 4'(g);
    assign hot_w[g] = smp <= {1'b0, tgt_offset};
    assign oos_w[g] = oos_now;
    assign smp_w[g] = smp;

    always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
        smp <= 7'h7f;
      end else if (smp_tick) begin
        smp <= sat;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
        th1 <= 7'h00;
        th2 <= 7'h00;
        en1 <= 1'b0;
        en2 <= 1'b0;
      end else if (thsel) begin
        th1 <= msr_req_i.wdata[`ATT_TH1_LSB +: 7];
        th2 <= msr_req_i.wdata[`ATT_TH2_LSB +: 7];
        en1 <= msr_req_i.wdata[`ATT_TH1_EN];
        en2 <= msr_req_i.wdata[`ATT_TH2_EN];
      end
    end

    // Logs clear on a write of zero; a same-cycle event still sets them
    always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
        t1      <= 1'b0;
        t2      <= 1'b0;
        t1_log  <= 1'b0;
        t2_log  <= 1'b0;
        oos_log <= 1'b0;
        act_log <= 1'b0;
        irq     <= 1'b0;
      end else begin
        t1      <= smp <= th1;
        t2      <= smp <= th2;
        t1_log  <= ((smp <= th1) != t1) | (t1_log & ~(wsel & ~msr_req_i.wdata[`ATT_ST_T1_LOG]));
        t2_log  <= ((smp <= th2) != t2) | (t2_log & ~(wsel & ~msr_req_i.wdata[`ATT_ST_T2_LOG]));
        oos_log <= oos_now | (oos_log & ~(wsel & ~msr_req_i.wdata[`ATT_ST_OOS_LOG]));
        act_log <= hot_w[g] | (act_log & ~(wsel & ~msr_req_i.wdata[`ATT_ST_ACT_LOG]));
        // Local interrupt path never sees the clock gate
        irq     <= (en1 & ((smp <= th1) != t1)) | (en2 & ((smp <= th2) != t2));
      end
    end

    assign thr_irq_o[g] = irq;
    assign thr_w[g]   = {46'h0, en2, en1, 1'b0, th2, 1'b0, th1};
    assign cstat_w[g] = {41'h0, smp, 8'h0, oos_log, oos_now, t2_log, t2, t1_log, t1, act_log, hot_w[g]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Package hottest reading and sideband average
  logic [6:0]  pkg_min;
  logic [31:0] avg_cnt;
  logic [7:0]  avg_n;
  logic [14:0] avg_acc;
  logic [6:0]  avg_val;
  logic        pkg_oos_log;
  logic        pkg_act_log;
  logic        psel;

  always_comb begin
    pkg_min = 7'h7f;
    for (int i = 0; i < NCORES; i++) begin
      if (smp_w[i] < pkg_min) pkg_min = smp_w[i];
    end
  end

  // Runs regardless of core idle state; only the core clock is needed
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      avg_cnt <= 32'h0;
      avg_n   <= 8'h00;
      avg_acc <= 15'h0000;
      avg_val <= 7'h00;
    end else if (avg_cnt == 32'(AVG_CYC - 1)) begin
      avg_cnt <= 32'h0;
      avg_n   <= avg_n + 8'h01;
      if (avg_n == 8'hff) begin
        avg_acc <= 15'h0000;
        avg_val <= 7'((avg_acc + {8'h00, pkg_min}) >> `ATT_AVG_SHIFT);
      end else begin
        avg_acc <= avg_acc + {8'h00, pkg_min};
      end
    end else begin
      avg_cnt <= avg_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sb_temp_vld_o <= 1'b0;
      sb_temp_o     <= 7'h00;
    end else begin
      sb_temp_vld_o <= sb_temp_req_i;
      if (sb_temp_req_i) sb_temp_o <= avg_val;
    end
  end

  assign psel = msr_wr && msr_req_i.addr == `ATT_MSR_PKG_STAT;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pkg_oos_log <= 1'b0;
      pkg_act_log <= 1'b0;
    end else begin
      pkg_oos_log <= (|oos_w) | (pkg_oos_log & ~(psel & ~msr_req_i.wdata[`ATT_ST_OOS_LOG]));
      pkg_act_log <= (|hot_w) | (pkg_act_log & ~(psel & ~msr_req_i.wdata[`ATT_ST_ACT_LOG]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal control: stepping, modulation, hysteresis
  logic [31:0] step_cnt;
  logic [31:0] hyst_cnt;
  logic [31:0] mod_cnt;
  logic [5:0]  therm_ratio;
  logic        modulate;
  logic        hot;

  assign hot = |hot_w;

  // No enable bit exists: activation depends on temperature only
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      act         <= 1'b0;
      modulate    <= 1'b0;
      therm_ratio <= RATIO_MAX;
      step_cnt    <= 32'h0;
      hyst_cnt    <= 32'h0;
    end else if (hot) begin
      act      <= 1'b1;
      hyst_cnt <= 32'h0;
      step_cnt <= (step_cnt == 32'(STEP_CYC - 1)) ? 32'h0 : step_cnt + 32'h1;
      if (act && step_cnt == 32'(STEP_CYC - 1)) begin
        if (therm_ratio > RATIO_MIN) therm_ratio <= therm_ratio - 6'h01;
        else modulate <= 1'b1;
      end
    end else if (act) begin
      step_cnt <= 32'h0;
      if (hyst_cnt == 32'(HYST_CYC - 1)) begin
        act         <= 1'b0;
        modulate    <= 1'b0;
        therm_ratio <= RATIO_MAX;
        hyst_cnt    <= 32'h0;
      end else begin
        hyst_cnt <= hyst_cnt + 32'h1;
      end
    end
  end

  // Fixed 32 us period, 25% on; counted on the core clock, not the core ratio
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mod_cnt       <= 32'h0;
      core_clk_en_o <= 1'b1;
    end else if (modulate) begin
      mod_cnt       <= (mod_cnt == 32'(`ATT_MOD_CYCLES - 1)) ? 32'h0 : mod_cnt + 32'h1;
      core_clk_en_o <= mod_cnt < 32'(`ATT_MOD_ON_CYCLES);
    end else begin
      mod_cnt       <= 32'h0;
      core_clk_en_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      overheat_flag_pin_o <= 1'b0;
      atm_active_o        <= 1'b0;
    end else begin
      overheat_flag_pin_o <= hot;
      atm_active_o        <= act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating point sequencer
  att_pkg::att_op_state_t op_st;
  logic [5:0]  sw_ratio;
  logic [5:0]  eff_tgt;
  logic [5:0]  op_tgt;
  logic [31:0] tr_cnt;
  logic        tr_done;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sw_ratio <= RATIO_MAX;
    end else if (pstate_vld_i) begin
      sw_ratio <= pstate_ratio_i;
    end
  end

  // Higher requests wait behind the thermal cap; lower ones pass straight through
  assign eff_tgt = (act && sw_ratio > therm_ratio) ? therm_ratio : sw_ratio;
  assign tr_done = tr_cnt == 32'(TRANS_CYC - 1);

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      op_st        <= att_pkg::OP_STEADY;
      op_tgt       <= RATIO_MAX;
      tr_cnt       <= 32'h0;
      freq_ratio_o <= RATIO_MAX;
      volt_level_o <= RATIO_MAX;
      exec_stall_o <= 1'b0;
    end else begin
      tr_cnt <= (op_st == att_pkg::OP_STEADY || tr_done) ? 32'h0 : tr_cnt + 32'h1;
      case (op_st)
        att_pkg::OP_STEADY: begin
          op_tgt <= eff_tgt;
          if (eff_tgt > freq_ratio_o) begin
            op_st <= att_pkg::OP_VOLT_UP;
          end else if (eff_tgt < freq_ratio_o) begin
            op_st        <= att_pkg::OP_FREQ_DN;
            exec_stall_o <= 1'b1;
          end
        end
        att_pkg::OP_VOLT_UP: begin
          if (tr_done) begin
            volt_level_o <= op_tgt;
            op_st        <= att_pkg::OP_FREQ_UP;
            exec_stall_o <= 1'b1;
          end
        end
        att_pkg::OP_FREQ_UP: begin
          if (tr_done) begin
            freq_ratio_o <= op_tgt;
            exec_stall_o <= 1'b0;
            op_st        <= att_pkg::OP_STEADY;
          end
        end
        att_pkg::OP_FREQ_DN: begin
          if (tr_done) begin
            freq_ratio_o <= op_tgt;
            exec_stall_o <= 1'b0;
            op_st        <= att_pkg::OP_VOLT_DN;
          end
        end
        att_pkg::OP_VOLT_DN: begin
          if (tr_done) begin
            volt_level_o <= op_tgt;
            op_st        <= att_pkg::OP_STEADY;
          end
        end
        default: op_st <= att_pkg::OP_STEADY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  logic [63:0] rd_mux;
  logic        core_ok;

  assign core_ok = 32'(msr_req_i.core) < 32'(NCORES);

  always_comb begin
    rd_mux = 64'h0;
    if (msr_req_i.addr == `ATT_MSR_TARGET) begin
      rd_mux[`ATT_TJMAX_LSB +: 8]  = TJMAX;
      rd_mux[`ATT_OFFSET_LSB +: 6] = tgt_offset;
    end else if (msr_req_i.addr == `ATT_MSR_CORE_STAT && core_ok) begin
      rd_mux = cstat_w[msr_req_i.core];
    end else if (msr_req_i.addr == `ATT_MSR_THRESH && core_ok) begin
      rd_mux = thr_w[msr_req_i.core];
    end else if (msr_req_i.addr == `ATT_MSR_PKG_STAT) begin
      rd_mux[`ATT_ST_ACT]               = hot;
      rd_mux[`ATT_ST_ACT_LOG]           = pkg_act_log;
      rd_mux[`ATT_ST_OOS]               = |oos_w;
      rd_mux[`ATT_ST_OOS_LOG]           = pkg_oos_log;
      rd_mux[`ATT_ST_READ_LSB +: 7]     = pkg_min;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      msr_ack_o   <= 1'b0;
      msr_rdata_o <= 64'h0;
    end else begin
      msr_ack_o <= msr_req_i.vld;
      if (msr_req_i.vld && !msr_req_i.wr) msr_rdata_o <= rd_mux;
    end
  end

endmodule // att_thermal_throttle

// file: common/att_params.svh
`ifndef ATT_PARAMS_SVH
`define ATT_PARAMS_SVH
// Register addresses
`define ATT_MSR_THRESH      12'h19b
`define ATT_MSR_CORE_STAT   12'h19c
`define ATT_MSR_TARGET      12'h1a2
`define ATT_MSR_PKG_STAT    12'h1b1
// Target register fields
`define ATT_TJMAX_LSB       16
`define ATT_OFFSET_LSB      24
`define ATT_TJMAX_RST       8'h5f
`define ATT_OFFSET_RST      6'h00
// Status register fields
`define ATT_ST_ACT          0
`define ATT_ST_ACT_LOG      1
`define ATT_ST_T1           2
`define ATT_ST_T1_LOG       3
`define ATT_ST_T2           4
`define ATT_ST_T2_LOG       5
`define ATT_ST_OOS          6
`define ATT_ST_OOS_LOG      7
`define ATT_ST_READ_LSB     16
// Threshold register fields
`define ATT_TH1_LSB         0
`define ATT_TH2_LSB         8
`define ATT_TH1_EN          16
`define ATT_TH2_EN          17
// Timing
`define ATT_CLK_PERIOD_NS   8
`define ATT_MOD_PERIOD_NS   32000
`define ATT_MOD_CYCLES      (`ATT_MOD_PERIOD_NS / `ATT_CLK_PERIOD_NS)
`define ATT_MOD_ON_CYCLES   (`ATT_MOD_CYCLES / 4)
`define ATT_AVG_WINDOW_MS   256
`define ATT_AVG_SHIFT       8
`define ATT_AVG_SAMPLE_CYC  ((`ATT_AVG_WINDOW_MS * 1000000 / `ATT_CLK_PERIOD_NS) >> `ATT_AVG_SHIFT)
`define ATT_STEP_US         10
`define ATT_STEP_CYC        (`ATT_STEP_US * 1000 / `ATT_CLK_PERIOD_NS)
`define ATT_HYST_US         1000
`define ATT_HYST_CYC        (`ATT_HYST_US * 1000 / `ATT_CLK_PERIOD_NS)
`define ATT_SAMPLE_US       100
`define ATT_SAMPLE_CYC      (`ATT_SAMPLE_US * 1000 / `ATT_CLK_PERIOD_NS)
`define ATT_TRANS_CYC       16
`define ATT_RAPID_DELTA     7'h05
`endif

// file: common/att_pkg.sv
package att_pkg;
  typedef struct packed {
    logic        vld;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  core;
    logic [63:0] wdata;
  } att_msr_req_t;

  typedef enum logic [2:0] {
    OP_STEADY,
    OP_VOLT_UP,
    OP_FREQ_UP,
    OP_FREQ_DN,
    OP_VOLT_DN
  } att_op_state_t;
endpackage

// file: test/att_thermal_chk.sv
`timescale 1ns/10ps
module att_thermal_chk #(
  parameter logic [5:0] RATIO_MIN = 6'h04
) (
  input wire logic                  core_clk_i,
  input wire logic                  resetn_i,
  input wire att_pkg::att_msr_req_t msr_req_i,
  input wire logic                  msr_ack_o,
  input wire logic                  sb_temp_req_i,
  input wire logic                  sb_temp_vld_o,
  input wire logic [5:0]            freq_ratio_o,
  input wire logic [5:0]            volt_level_o,
  input wire logic                  core_clk_en_o,
  input wire logic                  exec_stall_o,
  input wire logic                  overheat_flag_pin_o,
  input wire logic                  atm_active_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [31:0] hi_run;
  logic [31:0] lo_run;
  logic        mod_seen;
  ////////////////////////////////////////////////////////////////////////////
  // Run lengths of the clock enable; the first high run is ignored since it
  // started long before modulation
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || core_clk_en_o) begin
      lo_run <= 32'h0;
    end else begin
      lo_run <= lo_run + 32'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || !core_clk_en_o) begin
      hi_run <= 32'h0;
    end else begin
      hi_run <= hi_run + 32'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || !atm_active_o) begin
      mod_seen <= 1'b0;
    end else if (!core_clk_en_o) begin
      mod_seen <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property (msr_ack_o == $past(msr_req_i.vld))
    else $error("register ack does not follow its request");
  a_sb_answer_once: assert property (sb_temp_req_i |=> sb_temp_vld_o ##1 !sb_temp_vld_o)
    else $error("sideband answer missing or too long");
  a_pin_needs_active: assert property (overheat_flag_pin_o |=> atm_active_o)
    else $error("overheat pin without active monitor");
  a_volt_leads_up: assert property ((freq_ratio_o > $past(freq_ratio_o)) |-> (volt_level_o >= freq_ratio_o))
    else $error("frequency raised before voltage");
  a_freq_leads_down: assert property ((volt_level_o < $past(volt_level_o)) |-> (freq_ratio_o <= volt_level_o))
    else $error("voltage lowered before frequency");
  a_freq_in_stall: assert property ($changed(freq_ratio_o) |-> $past(exec_stall_o))
    else $error("frequency changed without stall");
  a_stall_bounded: assert property ($rose(exec_stall_o) |-> ##[1:8] $changed(freq_ratio_o))
    else $error("stall without frequency change");
  a_mod_at_min: assert property ($fell(core_clk_en_o) |-> freq_ratio_o == RATIO_MIN)
    else $error("clock gated above minimum ratio");
  a_gate_needs_hot: assert property (!core_clk_en_o |-> (atm_active_o || $past(atm_active_o)))
    else $error("clock gated while monitor inactive");
  a_low_three_quarters: assert property ($rose(core_clk_en_o) && atm_active_o |-> lo_run == 32'hbb8)
    else $error("gated phase length wrong");
  a_high_one_quarter: assert property ($fell(core_clk_en_o) && mod_seen |-> hi_run == 32'h3e8)
    else $error("running phase length wrong");
endmodule // att_thermal_chk

// file: test/att_sb_poller.sv
`timescale 1ns/10ps
module att_sb_poller (
  input  wire logic       clk_i,
  input  wire logic       vld_i,
  input  wire logic [6:0] temp_i,
  output logic            req_o
);
  initial req_o = 1'b0;
  // One poll: a single-cycle request, answer taken while valid is up
  task automatic poll(output logic [6:0] t);
    int n;
    n = 0;
    @(negedge clk_i);
    req_o = 1'b1;
    @(negedge clk_i);
    req_o = 1'b0;
    while (vld_i !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    // No answer leaves an unknown so the compare cannot pass by chance
    t = (vld_i === 1'b1) ? temp_i : 7'hxx;
  endtask
endmodule // att_sb_poller

// file: test/testbench.sv
`timescale 1ns/10ps
`include "att_params.svh"
module testbench;
  logic                  core_clk_i;
  logic                  resetn_i;
  logic [1:0][7:0]       sens;
  logic                  ps_vld;
  logic [5:0]            ps_ratio;
  att_pkg::att_msr_req_t req;
  logic                  ack, sb_req, sb_vld, clk_en, stall, pin, active;
  logic [63:0]           rdata, rd;
  logic [6:0]            sb_temp, seen;
  logic [5:0]            freq, volt;
  logic [1:0]            irq;
  int                    n_mismatch, check_count, cyc, irq0, irq1, lo;
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  att_thermal_throttle #(.STEP_CYC(4), .HYST_CYC(20), .SAMPLE_CYC(2), .AVG_CYC(1), .TRANS_CYC(2)) dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .sensor_i(sens), .pstate_vld_i(ps_vld),
    .pstate_ratio_i(ps_ratio), .msr_req_i(req), .msr_ack_o(ack), .msr_rdata_o(rdata),
    .sb_temp_req_i(sb_req), .sb_temp_vld_o(sb_vld), .sb_temp_o(sb_temp), .freq_ratio_o(freq),
    .volt_level_o(volt), .core_clk_en_o(clk_en), .exec_stall_o(stall), .overheat_flag_pin_o(pin),
    .atm_active_o(active), .thr_irq_o(irq));
  att_sb_poller poller (.clk_i(core_clk_i), .vld_i(sb_vld), .temp_i(sb_temp), .req_o(sb_req));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic msr(input logic w, input logic [11:0] a, input logic [3:0] c, input logic [63:0] wd);
    @(negedge core_clk_i);
    req = '{1'b1, w, a, c, wd};
    @(negedge core_clk_i);
    // Ack stands for one cycle only and read data only until the next read, so take them here
    check(ack, 1'b1);
    rd = rdata;
    req.vld = 1'b0;
  endtask
  task automatic pstate(input logic [5:0] r);
    @(negedge core_clk_i);
    ps_vld = 1'b1;
    ps_ratio = r;
    @(negedge core_clk_i);
    ps_vld = 1'b0;
  endtask
  task automatic until_act(input logic v);
    for (int i = 0; i < 300 && active !== v; i++) @(negedge core_clk_i);
    check(active, v);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard well above the roughly 10000 cycles the tests need
  always @(negedge core_clk_i) begin
    cyc++;
    if (irq[0] === 1'b1) irq0++;
    if (irq[1] === 1'b1) irq1++;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    resetn_i = 1'b0;
    sens = {8'h7f, 8'h7f};
    ps_vld = 1'b0;
    ps_ratio = 6'h20;
    req = '0;
    repeat (20) @(negedge core_clk_i);
    resetn_i = 1'b1;
    check({freq, volt, clk_en, active}, {6'h20, 6'h20, 1'b1, 1'b0});
    msr(1'b1, `ATT_MSR_TARGET, 4'h0, 64'h0a00_0000);
    msr(1'b0, `ATT_MSR_TARGET, 4'h0, 64'h0);
    check(rd[29:16], {6'h0a, `ATT_TJMAX_RST});
    msr(1'b1, 12'h123, 4'h0, '1);
    msr(1'b0, 12'h123, 4'h0, 64'h0);
    check(rd, 64'h0);
    msr(1'b0, `ATT_MSR_CORE_STAT, 4'h2, 64'h0);
    check(rd, 64'h0);
    $display("target register test done");
    sens[0] = 8'h0b;
    repeat (20) @(negedge core_clk_i);
    check(active, 1'b0);
    sens[0] = 8'h0a;
    until_act(1'b1);
    repeat (4) @(negedge core_clk_i);
    check(pin, 1'b1);
    msr(1'b0, `ATT_MSR_CORE_STAT, 4'h0, 64'h0);
    check({rd[22:16], rd[7], rd[1:0]}, {7'h0a, 1'b1, 2'b11});
    msr(1'b0, `ATT_MSR_PKG_STAT, 4'h0, 64'h0);
    check({rd[22:16], rd[7], rd[0]}, {7'h0a, 1'b1, 1'b1});
    sens[0] = 8'h7f;
    msr(1'b1, `ATT_MSR_TARGET, 4'h0, 64'h0);
    until_act(1'b0);
    $display("offset activation test done");
    sens[1] = 8'h85;
    until_act(1'b1);
    pstate(6'h08);
    repeat (30) @(negedge core_clk_i);
    check(freq, 6'h08);
    for (int i = 0; i < 400 && freq !== 6'h04; i++) @(negedge core_clk_i);
    pstate(6'h18);
    // Gating starts only after the first 1000-cycle running phase
    for (int i = 0; i < 1200 && clk_en !== 1'b0; i++) @(negedge core_clk_i);
    check({freq, volt, clk_en}, {6'h04, 6'h04, 1'b0});
    lo = 0;
    repeat (8000) begin
      @(negedge core_clk_i);
      if (clk_en === 1'b0) lo++;
    end
    check(lo, 6000);
    check(freq, 6'h04);
    msr(1'b0, `ATT_MSR_CORE_STAT, 4'h1, 64'h0);
    check({rd[22:16], rd[1:0]}, {7'h00, 2'b11});
    $display("throttle and modulation test done");
    msr(1'b1, `ATT_MSR_THRESH, 4'h0, 64'h1_0020);
    sens = {8'h30, 8'h40};
    until_act(1'b0);
    repeat (600) @(negedge core_clk_i);
    check({freq, volt, clk_en}, {6'h18, 6'h18, 1'b1});
    poller.poll(seen);
    check(seen, 7'h30);
    sens[0] = 8'h18;
    repeat (10) @(negedge core_clk_i);
    check({irq0, irq1}, {32'h1, 32'h0});
    msr(1'b0, `ATT_MSR_CORE_STAT, 4'h0, 64'h0);
    check(rd[3:2], 2'b11);
    $display("recovery, sideband and threshold test done");
    give_verdict();
  end
endmodule // testbench
bind att_thermal_throttle att_thermal_chk #(.RATIO_MIN(RATIO_MIN)) u_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .msr_req_i(msr_req_i), .msr_ack_o(msr_ack_o),
  .sb_temp_req_i(sb_temp_req_i), .sb_temp_vld_o(sb_temp_vld_o), .freq_ratio_o(freq_ratio_o),
  .volt_level_o(volt_level_o), .core_clk_en_o(core_clk_en_o), .exec_stall_o(exec_stall_o),
  .overheat_flag_pin_o(overheat_flag_pin_o), .atm_active_o(atm_active_o));
